// [hw/sbss_pkg.sv]
// sbss_pkg: register map, field layout, reset values and timing constants
// for the servo brake and stop sequencer; assumes a 100 MHz system clock.
package sbss_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_MS         = 10;
  localparam int unsigned TICK_CYC        = CLK_HZ / 1000 * TICK_MS;

  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_SPD_THR    = 8'h04;
  localparam logic [7:0]  ADDR_WAIT       = 8'h08;
  localparam logic [7:0]  ADDR_OFF_DELAY  = 8'h0c;
  localparam logic [7:0]  ADDR_STOP_CFG   = 8'h10;
  localparam logic [7:0]  ADDR_STATUS     = 8'h14;
  localparam logic [7:0]  ADDR_MAX_SPEED  = 8'h18;

  localparam logic [13:0] SPD_THR_MAX     = 14'h2710;
  localparam logic [13:0] SPD_THR_RST     = 14'h0064;
  localparam logic [6:0]  WAIT_MIN        = 7'h0a;
  localparam logic [6:0]  WAIT_MAX        = 7'h64;
  localparam logic [6:0]  WAIT_RST        = 7'h32;
  localparam logic [5:0]  OFF_DELAY_MAX   = 6'h32;
  localparam logic [5:0]  OFF_DELAY_RST   = 6'h00;
  localparam logic [1:0]  STOP_SEL_RST    = 2'h0;
  localparam logic        G2_SEL_RST      = 1'b0;
  localparam logic [13:0] MAX_SPEED_RST   = 14'h0bb8;

  localparam int unsigned STOP_SEL_LSB    = 0;
  localparam int unsigned G2_SEL_BIT      = 4;
  localparam int unsigned CTRL_RESTART    = 0;

  typedef enum logic [1:0] {
    SBSS_CTRL_POSITION,
    SBSS_CTRL_SPEED,
    SBSS_CTRL_TORQUE
  } sbss_ctrl_mode_t;

  typedef enum logic [1:0] {
    SBSS_MOTOR_RUN,
    SBSS_MOTOR_DB,
    SBSS_MOTOR_COAST,
    SBSS_MOTOR_ZERO
  } sbss_motor_t;

  typedef enum {
    SBSS_ON,
    SBSS_OFF_DELAY,
    SBSS_SPIN_DOWN,
    SBSS_ZERO_STOP,
    SBSS_HALTED
  } sbss_state_t;

endpackage : sbss_pkg

// [hw/sbss_top.sv]
// sbss_top: brake release output and stop-method sequencing of a servo drive.
// assumes servo commands and motor speed are synchronous to clk_sys; APB slave.
//
// Behaviour
// - alarm while stopped: stop motor and deassert brake release
// - speed threshold 0..10000 rpm, default 100, used immediately
// - wait time 10..100 in 10 ms units, default 50, used immediately
// - after power off while rotating, apply brake when speed below threshold
// - or when wait time exceeded, whichever comes first
// - threshold above maximum motor speed is limited to maximum speed
// - zero-speed stop: once stopped, use stationary brake timing
// - servo off: select 0 brake-hold, 1 brake-then-coast, 2 coast
// - group one alarm stops as the servo-off stop method
// - group two: zero-speed stop when selection 0, else as group one
// - zero-speed stop forces speed reference to zero
// - group two selection honoured only in position and speed control
// - brake release high means released; drop on alarm or servo off
// - stationary servo off: brake at once, power off after delay 0..50
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module sbss_top
  import sbss_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        servo_on_cmd,
  input  wire logic        servo_off_cmd,
  input  wire logic        alarm_group_one,
  input  wire logic        alarm_group_two,
  input  wire logic [1:0]  ctrl_mode,
  input  wire logic [13:0] motor_speed,
  input  wire logic        motor_rotating,
  output logic             brake_release_out,
  output logic             motor_power_en,
  output logic             dynamic_braking,
  output logic             zero_speed_ref
);

  typedef struct packed {
    logic [13:0]  spd_thr;
    logic [6:0]   wait_time;
    logic [5:0]   off_delay;
    logic [13:0]  max_speed;
    logic [1:0]   sel_pending;
    logic         g2_pending;
    logic [1:0]   stop_sel;
    logic         g2_sel;
    logic         restart;
    sbss_state_t  st;
    sbss_motor_t  motor;
    logic         brake_rel;
    logic [19:0]  tick_cnt;
    logic [6:0]   ticks;
    logic [31:0]  rdata;
  } sbss_regs_t;

  sbss_regs_t r;
  sbss_regs_t next_r;

  function automatic logic [13:0] sbss_eff_thr(input logic [13:0] thr,
                                              input logic [13:0] vmax);
    sbss_eff_thr = (thr > vmax) ? vmax : thr;
  endfunction : sbss_eff_thr

  function automatic logic sbss_known(input logic [7:0] a);
    sbss_known = (a == ADDR_CTRL) || (a == ADDR_SPD_THR) || (a == ADDR_WAIT) ||
                 (a == ADDR_OFF_DELAY) || (a == ADDR_STOP_CFG) ||
                 (a == ADDR_STATUS) || (a == ADDR_MAX_SPEED);
  endfunction : sbss_known

  logic acc;
  logic wr;
  logic alarm_any;
  logic use_zero;
  logic tick;
  logic [13:0] thr_eff;

  assign acc       = psel && penable;
  assign wr        = acc && pwrite;
  assign alarm_any = alarm_group_one || alarm_group_two;
  assign tick      = (r.tick_cnt == 20'(TICK_CYC - 1));
  assign thr_eff   = sbss_eff_thr(r.spd_thr, r.max_speed);
  // zero-speed stop only for group two, selection 0, not torque control
  assign use_zero  = alarm_group_two && !alarm_group_one && !r.g2_sel &&
                     (ctrl_mode != 2'(SBSS_CTRL_TORQUE));

  ////////////////////////////////////////////////////////////////////////////
  // register bus and sequencer

  always_comb begin
    next_r = r;
    next_r.restart = 1'b0;
    next_r.tick_cnt = tick ? 20'h0 : r.tick_cnt + 20'h1;
    // read data latched at the setup edge so it stands through the access phase
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_SPD_THR:   next_r.rdata = {18'h0, r.spd_thr};
        ADDR_WAIT:      next_r.rdata = {25'h0, r.wait_time};
        ADDR_OFF_DELAY: next_r.rdata = {26'h0, r.off_delay};
        ADDR_STOP_CFG:  next_r.rdata = {27'h0, r.g2_pending, 2'h0, r.sel_pending};
        ADDR_STATUS:    next_r.rdata = {19'h0, r.ticks, r.motor, r.brake_rel,
                                        3'(r.st) };
        ADDR_MAX_SPEED: next_r.rdata = {18'h0, r.max_speed};
        default:        next_r.rdata = 32'h0;
      endcase
    end
    if (wr) begin
      case (paddr)
        ADDR_CTRL:      next_r.restart = pwdata[CTRL_RESTART];
        ADDR_SPD_THR:
          if (pwdata[13:0] <= SPD_THR_MAX) next_r.spd_thr = pwdata[13:0];
        ADDR_WAIT:
          if (pwdata[6:0] >= WAIT_MIN && pwdata[6:0] <= WAIT_MAX && pwdata[31:7] == 25'h0)
            next_r.wait_time = pwdata[6:0];
        ADDR_OFF_DELAY:
          if (pwdata[5:0] <= OFF_DELAY_MAX && pwdata[31:6] == 26'h0)
            next_r.off_delay = pwdata[5:0];
        ADDR_STOP_CFG: begin
          if (pwdata[STOP_SEL_LSB +: 2] != 2'h3) next_r.sel_pending = pwdata[1:0];
          next_r.g2_pending = pwdata[G2_SEL_BIT];
        end
        ADDR_MAX_SPEED: next_r.max_speed = pwdata[13:0];
        default: ;
      endcase
    end
    if (r.restart) begin
      next_r.stop_sel = r.sel_pending;
      next_r.g2_sel   = r.g2_pending;
    end
    // brake wait timer in 10 ms ticks, cleared in SBSS_ON and on leaving SBSS_ZERO_STOP
    if (r.st == SBSS_ON) begin
      next_r.ticks = 7'h0;
    end else if (tick && r.ticks != 7'h7f) begin
      next_r.ticks = r.ticks + 7'h1;
    end
    case (r.st)
      SBSS_ON: begin
        next_r.motor = SBSS_MOTOR_RUN;
        next_r.brake_rel = servo_on_cmd ? 1'b1 : r.brake_rel;
        if (alarm_any || servo_off_cmd) begin
          next_r.brake_rel = 1'b0;
          next_r.ticks = 7'h0;
          next_r.tick_cnt = 20'h0;
          if (use_zero && motor_rotating) begin
            next_r.st = SBSS_ZERO_STOP;
            next_r.motor = SBSS_MOTOR_ZERO;
            next_r.brake_rel = 1'b1;
          end else if (!motor_rotating && !alarm_any) begin
            next_r.st = SBSS_OFF_DELAY;
          end else begin
            next_r.st = motor_rotating ? SBSS_SPIN_DOWN : SBSS_HALTED;
            next_r.motor = (r.stop_sel == 2'h2) ? SBSS_MOTOR_COAST
                                                : SBSS_MOTOR_DB;
            next_r.brake_rel = motor_rotating;
          end
        end
      end
      SBSS_OFF_DELAY: begin
        next_r.brake_rel = 1'b0;
        if (alarm_any || r.ticks >= 7'(r.off_delay)) begin
          next_r.st = SBSS_HALTED;
          next_r.motor = (r.stop_sel == 2'h2) ? SBSS_MOTOR_COAST : SBSS_MOTOR_DB;
        end
      end
      SBSS_ZERO_STOP: begin
        if (!motor_rotating) begin
          next_r.st = SBSS_OFF_DELAY;
          next_r.brake_rel = 1'b0;
          next_r.ticks = 7'h0;
        end
      end
      SBSS_SPIN_DOWN: begin
        if (motor_speed < thr_eff || r.ticks > r.wait_time) begin
          next_r.brake_rel = 1'b0;
          next_r.st = SBSS_HALTED;
        end
      end
      SBSS_HALTED: begin
        next_r.brake_rel = 1'b0;
        if (r.motor != SBSS_MOTOR_RUN && !motor_rotating)
          next_r.motor = (r.stop_sel == 2'h0) ? SBSS_MOTOR_DB : SBSS_MOTOR_COAST;
        if (servo_on_cmd && !alarm_any && !servo_off_cmd) begin
          next_r.st = SBSS_ON;
          next_r.motor = SBSS_MOTOR_RUN;
          next_r.brake_rel = 1'b1;
        end
      end
      default: next_r.st = SBSS_HALTED;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{spd_thr: SPD_THR_RST, wait_time: WAIT_RST, off_delay: OFF_DELAY_RST,
             max_speed: MAX_SPEED_RST, sel_pending: STOP_SEL_RST,
             g2_pending: G2_SEL_RST, stop_sel: STOP_SEL_RST, g2_sel: G2_SEL_RST,
             restart: 1'b1, st: SBSS_HALTED, motor: SBSS_MOTOR_DB,
             brake_rel: 1'b0, tick_cnt: 20'h0, ticks: 7'h0, rdata: 32'h0};
    end else begin
      r <= next_r;
    end
  end

  assign prdata            = r.rdata;
  assign pready            = 1'b1;
  assign pslverr           = acc && !sbss_known(paddr);
  assign brake_release_out = r.brake_rel;
  assign motor_power_en    = (r.st == SBSS_ON) || (r.st == SBSS_OFF_DELAY) ||
                             (r.st == SBSS_ZERO_STOP);
  assign dynamic_braking   = (r.motor == SBSS_MOTOR_DB);
  assign zero_speed_ref    = (r.motor == SBSS_MOTOR_ZERO);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_power_removed;
    $past(r.st) != SBSS_HALTED && r.st == SBSS_HALTED;
  endsequence

  chk_alarm_drops_brake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.st == SBSS_ON && alarm_any && !use_zero && !motor_rotating) |=> !brake_release_out)
    else $error("brake not applied after alarm");

  chk_alarm_power_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.st == SBSS_ON && alarm_any && !use_zero) |=> !motor_power_en)
    else $error("motor power kept after alarm");

  chk_servo_off_brake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.st == SBSS_ON && servo_off_cmd && !motor_rotating) |=> !brake_release_out)
    else $error("brake not applied after servo off");

  chk_speed_brake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.st == SBSS_SPIN_DOWN && motor_speed < thr_eff) |=> !brake_release_out)
    else $error("brake not applied below speed threshold");

  chk_wait_brake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.st == SBSS_SPIN_DOWN && r.ticks > r.wait_time) |=> !brake_release_out)
    else $error("brake not applied after wait time");

  chk_thr_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    thr_eff <= r.max_speed && thr_eff <= r.spd_thr)
    else $error("threshold not limited");

  chk_zero_ref: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.st == SBSS_ON && use_zero && motor_rotating && alarm_any) |=> zero_speed_ref)
    else $error("zero speed reference missing");

  chk_coast_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.st == SBSS_ON && servo_off_cmd && motor_rotating && r.stop_sel == 2'h2)
    |=> !dynamic_braking)
    else $error("coast mode used dynamic braking");

  chk_stop_sel_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(r.restart) |-> $stable(r.stop_sel) && $stable(r.g2_sel))
    else $error("stop selection changed without restart");

  chk_timer_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_power_removed |-> r.ticks <= r.wait_time + 7'h1 || $past(r.st) != SBSS_SPIN_DOWN)
    else $error("wait timer ran past limit");

  chk_timer_on_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.st == SBSS_ON) |=> r.ticks == 7'h0)
    else $error("wait timer not cleared while powered");

  chk_zero_stop_brake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.st == SBSS_ZERO_STOP && !motor_rotating)
    |=> (r.st == SBSS_OFF_DELAY && !brake_release_out))
    else $error("brake not applied after zero-speed stop");

  chk_off_delay_brake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.st == SBSS_OFF_DELAY) |-> !brake_release_out)
    else $error("brake released during power-off delay");

  chk_torque_no_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.st == SBSS_ON && ctrl_mode == 2'(SBSS_CTRL_TORQUE)) |=> !zero_speed_ref)
    else $error("zero-speed stop used in torque control");

  chk_group_one_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.st == SBSS_ON && alarm_group_one && motor_rotating && !r.restart)
    |=> (r.st == SBSS_SPIN_DOWN && dynamic_braking == (r.stop_sel != 2'h2)))
    else $error("group one alarm stop method wrong");

  sequence s_halted_at_rest;
    r.st == SBSS_HALTED && !motor_rotating && !servo_on_cmd && !r.restart;
  endsequence

  chk_rest_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_halted_at_rest |=> dynamic_braking == (r.stop_sel == 2'h0))
    else $error("mode after stopping wrong");

  chk_setting_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    r.spd_thr <= SPD_THR_MAX && r.wait_time >= WAIT_MIN && r.wait_time <= WAIT_MAX)
    else $error("setting outside its range");

endmodule : sbss_top

// [verif/sbss_motor_model.sv]
// sbss_motor_model: behavioural servomotor seen by the sequencer.
// assumes the design's power, braking and zero-reference outputs on clk_sys.
`timescale 1ns/1ns
module sbss_motor_model
  import sbss_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        motor_power_en,
  input  wire logic        dynamic_braking,
  input  wire logic        zero_speed_ref,
  input  wire logic [13:0] spin_target,
  output logic      [13:0] motor_speed,
  output logic             motor_rotating
);
  logic [13:0] step;

  // zero reference stops hardest, dynamic braking next, coasting slowest
  assign step = zero_speed_ref ? 14'h00c8 : (dynamic_braking ? 14'h003c : 14'h0014);
  // rotation detect is its own output, never shared with the brake release
  assign motor_rotating = (motor_speed != 14'h0000);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      motor_speed <= 14'h0000;
    end else if (motor_power_en && !zero_speed_ref) begin
      motor_speed <= (motor_speed + 14'h012c > spin_target) ? spin_target
                                                             : motor_speed + 14'h012c;
    end else begin
      motor_speed <= (motor_speed > step) ? motor_speed - step : 14'h0000;
    end
  end
endmodule : sbss_motor_model

// [verif/servo_brake_stop_sequencer_test.sv]
// servo_brake_stop_sequencer_test: register and stop-sequence tests.
// assumes sbss_top and the motor model; prdata valid in the access phase.
`timescale 1ns/1ns
module servo_brake_stop_sequencer_test
  import sbss_pkg::*;
;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        servo_on_cmd, servo_off_cmd, alarm_group_one, alarm_group_two;
  logic [1:0]  ctrl_mode;
  logic [13:0] motor_speed, spin_target, spd;
  logic        motor_rotating, brake_release_out, motor_power_en;
  logic        dynamic_braking, zero_speed_ref, err, dbm, zrm, dbe;
  int          n_errors, num_checks;

  sbss_top sbss_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .servo_on_cmd(servo_on_cmd), .servo_off_cmd(servo_off_cmd),
    .alarm_group_one(alarm_group_one), .alarm_group_two(alarm_group_two),
    .ctrl_mode(ctrl_mode), .motor_speed(motor_speed), .motor_rotating(motor_rotating),
    .brake_release_out(brake_release_out), .motor_power_en(motor_power_en),
    .dynamic_braking(dynamic_braking), .zero_speed_ref(zero_speed_ref));
  sbss_motor_model sbss_motor_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .motor_power_en(motor_power_en), .dynamic_braking(dynamic_braking),
    .zero_speed_ref(zero_speed_ref), .spin_target(spin_target),
    .motor_speed(motor_speed), .motor_rotating(motor_rotating));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task test_done();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 20) chk("pready", 32'h0, 32'h1);
    if (i == 20) test_done();
    err = pslverr;
    q   = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_for(input int which, input logic v, input int bound);
    logic s;
    for (int i = 0; i < bound; i++) begin
      @(posedge clk_sys);
      #1;
      case (which)
        0: s = motor_power_en;
        1: s = brake_release_out;
        default: s = motor_rotating;
      endcase
      if (s === v) return;
    end
    chk($sformatf("wait %0d", which), 32'h0, 32'h1);
    test_done();
  endtask : wait_for

  task power_up(input logic [13:0] target);
    @(posedge clk_sys);
    spin_target  <= target;
    servo_on_cmd <= 1'b1;
    wait_for(0, 1'b1, 100);
    @(posedge clk_sys);
    servo_on_cmd <= 1'b0;
    repeat (12) @(posedge clk_sys);
  endtask : power_up

  // spin up, apply a stop cause, note braking mid-stop, brake-fall speed, state at rest
  task run_stop(input int cause);
    power_up(14'h0bb8);
    @(posedge clk_sys);
    case (cause)
      0: servo_off_cmd <= 1'b1;
      1: alarm_group_one <= 1'b1;
      default: alarm_group_two <= 1'b1;
    endcase
    repeat (5) @(posedge clk_sys);
    #1 dbm = dynamic_braking;
    zrm = zero_speed_ref;
    wait_for(1, 1'b0, 2000);
    spd = motor_speed;
    wait_for(2, 1'b0, 2000);
    wait_for(0, 1'b0, 2000);
    repeat (3) @(posedge clk_sys);
    #1 dbe = dynamic_braking;
    @(posedge clk_sys);
    servo_off_cmd   <= 1'b0;
    alarm_group_one <= 1'b0;
    alarm_group_two <= 1'b0;
  endtask : run_stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {servo_on_cmd, servo_off_cmd, alarm_group_one, alarm_group_two} = 4'h0;
    ctrl_mode = 2'h0;
    spin_target = 14'h0000;
    rst_n = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_SPD_THR, 32'h0);
    chk("thr_rst", q, 32'h00000064);
    apb(1'b0, ADDR_WAIT, 32'h0);
    chk("wait_rst", q, 32'h00000032);
    apb(1'b0, ADDR_OFF_DELAY, 32'h0);
    chk("delay_rst", q, 32'h00000000);
    apb(1'b0, ADDR_STOP_CFG, 32'h0);
    chk("cfg_rst", q, 32'h00000000);
    apb(1'b1, ADDR_SPD_THR, 32'h00002711);
    apb(1'b0, ADDR_SPD_THR, 32'h0);
    chk("thr_over", q, 32'h00000064);
    apb(1'b1, ADDR_WAIT, 32'h00000009);
    apb(1'b0, ADDR_WAIT, 32'h0);
    chk("wait_under", q, 32'h00000032);
    apb(1'b1, ADDR_WAIT, 32'h00000064);
    apb(1'b0, ADDR_WAIT, 32'h0);
    chk("wait_max", q, 32'h00000064);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", err, 32'h1);
    $display("test registers done");
    power_up(14'h0000);
    @(posedge clk_sys);
    servo_off_cmd <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk("brake_still", brake_release_out, 32'h0);
    wait_for(0, 1'b0, 50);
    @(posedge clk_sys);
    servo_off_cmd <= 1'b0;
    $display("test stationary done");
    for (int sel = 0; sel < 3; sel++) begin
      apb(1'b1, ADDR_STOP_CFG, 32'(sel));
      apb(1'b1, ADDR_CTRL, 32'h00000001);
      run_stop(0);
      chk("db_mid", dbm, 32'(sel != 2));
      chk("db_end", dbe, 32'(sel == 0));
      chk("slow", 32'(spd < 14'h0064), 32'h1);
    end
    run_stop(1);
    chk("g1_db", dbm, 32'h0);
    apb(1'b1, ADDR_STOP_CFG, 32'h00000000);
    run_stop(0);
    chk("no_restart", dbm, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h00000001);
    run_stop(2);
    chk("g2_zero", zrm, 32'h1);
    chk("g2_hold", dbe, 32'h1);
    ctrl_mode <= 2'h2;
    run_stop(2);
    chk("trq_zero", zrm, 32'h0);
    chk("trq_db", dbm, 32'h1);
    ctrl_mode <= 2'h0;
    apb(1'b1, ADDR_STOP_CFG, 32'h00000010);
    apb(1'b1, ADDR_CTRL, 32'h00000001);
    run_stop(2);
    chk("g2_as_g1", 32'({zrm, dbm}), 32'h1);
    apb(1'b1, ADDR_SPD_THR, 32'h00002710);
    apb(1'b1, ADDR_MAX_SPEED, 32'h000001f4);
    run_stop(0);
    chk("thr_cap", 32'(spd < 14'h01f4), 32'h1);
    chk("thr_cap_lo", 32'(spd > 14'h0100), 32'h1);
    $display("test stop methods done");
    test_done();
  end
endmodule : servo_brake_stop_sequencer_test
